// ---- rtl/rst_nmi_pkg.sv ----
// constants for the reset / nmi / power-down gate
// assumes a 125 MHz cpu clock (8 ns period)
package rst_nmi_pkg;
	localparam int CLK_PERIOD_NS   = 8;
	// spike filter figures, in ns
	localparam int SPIKE_REJECT_NS = 10;
	localparam int SPIKE_PASS_NS   = 100;
	// a low shorter than the reject time never counts: round up
	localparam int REJECT_CYC      = (SPIKE_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// a low longer than the pass time always counts: round down, at least one
	localparam int PASS_CYC_RAW    = SPIKE_PASS_NS / CLK_PERIOD_NS;
	localparam int PASS_CYC        = (PASS_CYC_RAW < 1) ? 1 : PASS_CYC_RAW;
	localparam int FILT_CNT_W      = 8;
	localparam int SYNC_STAGES     = 2;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_POWER_DOWN
	} pwr_state_t;
endpackage

// ---- rtl/sync_if.sv ----
// bundle of synchronised pin levels passed from the synchroniser to the gate
// assumes a single clock domain
interface sync_if;
	logic reset_lvl_n;
	logic nmi_lvl_n;
	modport src (output reset_lvl_n, output nmi_lvl_n);
	modport dst (input reset_lvl_n, input nmi_lvl_n);
endinterface

// ---- rtl/pin_sync.sv ----
// two-stage synchroniser for the reset and nmi pins
// assumes the pins are free-running levels; reset state is idle high
module pin_sync
	import rst_nmi_pkg::*;
(
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	// raw pins
	input  wire logic i_reset_raw_n,
	input  wire logic i_nmi_raw_n,
	// synchronised levels
	sync_if.src       sync
);
	logic [1:0] meta_ff;
	logic [1:0] nxt_meta;
	logic [1:0] stab_ff;
	logic [1:0] nxt_stab;

	always_comb
	begin
		nxt_meta = {i_nmi_raw_n, i_reset_raw_n};
		// the first stage feeds only the second
		nxt_stab = meta_ff;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta_ff <= 2'h3;
			stab_ff <= 2'h3;
		end
		else
		begin
			meta_ff <= nxt_meta;
			stab_ff <= nxt_stab;
		end
	end

	assign sync.reset_lvl_n = stab_ff[0];
	assign sync.nmi_lvl_n   = stab_ff[1];
endmodule

// ---- rtl/reset_nmi_powerdown_gate.sv ----
// reset pin filter, nmi edge trap request and power-down gating
// assumes inputs synchronous-ish to i_ref_clk; i_rst_n is the power-on reset
//
// Functional notes
// - a low reset pin with the oscillator running puts the device into reset.
// - low pulses under 10 ns on the reset pin never cause a reset.
// - low pulses over 100 ns on the reset pin always cause a reset.
// - a falling edge on the nmi pin sends the cpu to the nmi trap routine.
// - a power-down instruction enters power-down only while the nmi pin is low.
// - with the nmi pin high a power-down instruction is ignored and running continues.
module reset_nmi_powerdown_gate
	import rst_nmi_pkg::*;
#(
	parameter int PASS_CYCLES = rst_nmi_pkg::PASS_CYC
)
(
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	// board pins
	input  wire logic i_reset_in_n,
	input  wire logic i_nmi_n,
	input  wire logic i_osc_running,
	// cpu side
	input  wire logic i_power_down_instruction,
	output logic      o_cpu_reset_n,
	output logic      o_nmi_trap,
	output logic      o_power_down,
	output logic      o_pd_ignored
);
	////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	// the low counter must be able to reach the threshold
	if (PASS_CYCLES < 1 || PASS_CYCLES >= (1 << FILT_CNT_W))
	begin : g_bad_pass
		$error("PASS_CYCLES out of range");
	end

	// the synchroniser module is built with exactly two stages
	if (SYNC_STAGES != 2)
	begin : g_bad_sync
		$error("SYNC_STAGES must be 2");
	end

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// a low sample counts only while the oscillator runs
	function automatic logic pin_counts(
		input logic lvl_n,
		input logic osc
	);
		return !lvl_n && osc;
	endfunction

	// high-to-low step between two consecutive samples
	function automatic logic fell_edge(
		input logic prev,
		input logic now
	);
		return prev && !now;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// synchroniser

	sync_if sync ();

	pin_sync u_sync (
		.i_ref_clk     (i_ref_clk),
		.i_rst_n       (i_rst_n),
		.i_reset_raw_n (i_reset_in_n),
		.i_nmi_raw_n   (i_nmi_n),
		.sync          (sync)
	);

	////////////////////////////////////////////////////////////////////////////
	// reset filter

	logic [FILT_CNT_W-1:0] low_cnt_ff;
	logic [FILT_CNT_W-1:0] nxt_low_cnt;
	logic                  cpu_rst_n_ff;
	logic                  nxt_cpu_rst_n;

	always_comb
	begin
		nxt_low_cnt   = low_cnt_ff;
		nxt_cpu_rst_n = cpu_rst_n_ff;
		// stopped oscillator: pin level is not honoured
		if (!pin_counts(sync.reset_lvl_n, i_osc_running))
		begin
			nxt_low_cnt   = '0;
			nxt_cpu_rst_n = 1'b1;
		end
		// count the low; short spikes die before reaching the threshold
		else if (low_cnt_ff < FILT_CNT_W'(PASS_CYCLES - 1))
		begin
			nxt_low_cnt = low_cnt_ff + FILT_CNT_W'(1);
		end
		else
		begin
			// PASS_CYCLES low samples: a pulse over the pass time always
			// gives at least that many, so it can never slip through
			nxt_cpu_rst_n = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			low_cnt_ff   <= '0;
			cpu_rst_n_ff <= 1'b0;
		end
		else
		begin
			low_cnt_ff   <= nxt_low_cnt;
			cpu_rst_n_ff <= nxt_cpu_rst_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// nmi edge

	logic nmi_prev_ff;
	logic nxt_nmi_prev;
	logic trap_ff;
	logic nxt_trap;

	always_comb
	begin
		nxt_nmi_prev = sync.nmi_lvl_n;
		// no trap request while the cpu is held in reset
		nxt_trap     = fell_edge(nmi_prev_ff, sync.nmi_lvl_n) && cpu_rst_n_ff;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			// idle level of the pin, so no false edge after reset
			nmi_prev_ff <= 1'b1;
			trap_ff     <= 1'b0;
		end
		else
		begin
			nmi_prev_ff <= nxt_nmi_prev;
			trap_ff     <= nxt_trap;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power-down gate

	logic       ign_ff;
	logic       nxt_ign;
	logic       pd_ff;
	logic       nxt_pd;
	pwr_state_t state_ff;
	pwr_state_t nxt_state;

	always_comb
	begin
		nxt_ign      = 1'b0;
		nxt_state    = state_ff;
		unique case (state_ff)
			ST_RUN:
			begin
				if (i_power_down_instruction && cpu_rst_n_ff)
				begin
					if (!sync.nmi_lvl_n)
						nxt_state = ST_POWER_DOWN;
					else
						nxt_ign = 1'b1;
				end
			end
			ST_POWER_DOWN:
			begin
				// only a reset leaves power-down
				nxt_state = ST_POWER_DOWN;
			end
			default:
			begin
				nxt_state = ST_RUN;
			end
		endcase
		if (!cpu_rst_n_ff)
			nxt_state = ST_RUN;
		// registered copy of the state, so the output needs no decode
		nxt_pd = (nxt_state == ST_POWER_DOWN);
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ign_ff   <= 1'b0;
			pd_ff    <= 1'b0;
			state_ff <= ST_RUN;
		end
		else
		begin
			ign_ff   <= nxt_ign;
			pd_ff    <= nxt_pd;
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops

	assign o_cpu_reset_n = cpu_rst_n_ff;
	assign o_nmi_trap    = trap_ff;
	assign o_power_down  = pd_ff;
	assign o_pd_ignored  = ign_ff;
endmodule

// ---- testbench/board_src.sv ----
// board reset source model
// assumes i_len is seen at one rising edge only
module board_src (
	input  wire logic       i_ref_clk,
	input  wire logic [7:0] i_len,
	output logic            o_reset_in_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_ff = 8'h00;
	// board pull-up between frames
	assign o_reset_in_n = (cnt_ff == 8'h00);
	always @(posedge i_ref_clk)
		if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
		else cnt_ff <= i_len;
endmodule

// ---- testbench/reset_nmi_powerdown_gate_sva.sv ----
// port checks of the gate
// assumes one clock domain
module gate_chk #(
	parameter int PASS_CYCLES = 2
)
(
	input wire logic i_ref_clk, i_rst_n, i_reset_in_n, i_nmi_n, i_osc_running, i_power_down_instruction,
	input wire logic o_cpu_reset_n, o_nmi_trap, o_power_down, o_pd_ignored
);
	// low run of the pin, oscillator on
	logic [7:0] lo_ff;
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
		if (!i_rst_n) lo_ff <= 8'h00;
		else lo_ff <= (i_reset_in_n | !i_osc_running) ? 8'h00 : lo_ff + 8'h01;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_pd_req;
		i_power_down_instruction && o_cpu_reset_n && !o_power_down;
	endsequence
	chk_reset_take: assert property (lo_ff == PASS_CYCLES + 5 |-> !o_cpu_reset_n)
		else $error("reset late");
	chk_spike_drop: assert property ($fell(o_cpu_reset_n) |-> lo_ff > PASS_CYCLES)
		else $error("short low reset");
	chk_sync_lag: assert property ($rose(i_reset_in_n) && !o_cpu_reset_n |-> !o_cpu_reset_n[*2])
		else $error("reset left early");
	chk_trap_edge: assert property ($fell(i_nmi_n) && o_cpu_reset_n |-> ##[1:3] o_nmi_trap)
		else $error("trap missing");
	chk_trap_pulse: assert property (o_nmi_trap |-> !$past(i_nmi_n, 2) ##1 !o_nmi_trap)
		else $error("trap wrong");
	chk_pd_enter: assert property (!i_nmi_n[*4] ##0 s_pd_req |=> o_power_down && !o_pd_ignored)
		else $error("no power-down");
	chk_pd_refuse: assert property (i_nmi_n[*4] ##0 s_pd_req |=> o_pd_ignored && !o_power_down)
		else $error("power-down taken");
endmodule
bind reset_nmi_powerdown_gate gate_chk #(.PASS_CYCLES(PASS_CYCLES)) i_gate_chk (.*);

// ---- testbench/reset_nmi_powerdown_gate_tb.sv ----
// bench for the gate
// assumes board_src drives the reset pin
module reset_nmi_powerdown_gate_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 0, i_rst_n = 0, i_nmi_n = 1, i_osc_running = 1, i_power_down_instruction = 0;
	logic [7:0] len = 8'h00;
	logic i_reset_in_n, o_cpu_reset_n, o_nmi_trap, o_power_down, o_pd_ignored;
	int n_errors = 0, checked = 0, seed = 75, cyc = 0, traps = 0, t0;
	always #4 i_ref_clk = ~i_ref_clk;
	board_src i_board_src (.i_ref_clk, .i_len(len), .o_reset_in_n(i_reset_in_n));
	reset_nmi_powerdown_gate #(.PASS_CYCLES(2)) i_reset_nmi_powerdown_gate (.i_ref_clk, .i_rst_n, .i_reset_in_n,
		.i_nmi_n, .i_osc_running, .i_power_down_instruction, .o_cpu_reset_n, .o_nmi_trap, .o_power_down, .o_pd_ignored);
	task automatic conclude();
		if (n_errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input logic [1:0] g, input logic [1:0] e);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected %0t %h %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask
	// returns while the pin is still low
	task automatic hold(input logic [7:0] n);
		len = n;
		tick(1);
		len = 8'h00;
		tick(int'(n) - 1);
	endtask
	always @(posedge i_ref_clk)
	begin
		traps += int'(o_nmi_trap === 1'b1);
		if (++cyc == 3000)
		begin
			n_errors++;
			conclude();
		end
	end
	initial
	begin
		tick(16);
		i_rst_n = 1;
		tick(4);
		hold(8'h01);
		tick(6);
		cmp({1'b0, o_cpu_reset_n}, 2'h1);
		hold(8'h08);
		cmp({1'b0, o_cpu_reset_n}, 2'h0);
		tick(2);
		cmp({1'b0, o_cpu_reset_n}, 2'h0);
		tick(3);
		i_osc_running = 0;
		hold(8'h08);
		cmp({1'b0, o_cpu_reset_n}, 2'h1);
		tick(5);
		i_osc_running = 1;
		t0 = traps;
		i_nmi_n = 0;
		tick(6);
		cmp(2'(traps - t0), 2'h1);
		repeat (8)
		begin
			i_nmi_n = 1'($random(seed));
			tick(5);
			i_power_down_instruction = 1;
			tick(1);
			i_power_down_instruction = 0;
			cmp({o_power_down, o_pd_ignored}, {~i_nmi_n, i_nmi_n});
			if (o_power_down === 1'b1) hold(8'h08);
			tick(5);
		end
		conclude();
	end
endmodule
